// ==== src/sscr_regs.v ====
// Notes on behaviour
// - All-response clear: answer enables drop on BSY answer, bus reset, unexpected disconnect.
// - All-response set: answer enables also drop when matching vector enables drop.
// - Pause bit stops a non-register-file transfer at block boundary, target mode only.
// - After the bus transfer stops, instruction transfer completes, hardware clears pause one edge later.
// - Sending: DMA side stops at next or current boundary; FIFO drains, then proceed.
// - Receiving: stop at next boundary; on boundary already, one more block first.
// - Without pause, transfer ends when count pipeline goes busy to idle.
// - Reconnect enable: valid DMA request starts sequencer at DMA reconnect vector.
// - Reselect vector enable: reselection starts sequencer at reselection vector.
// - Reselect answer enable permits reselection answer; cleared by disconnect, reset, connect.
// - Select vector enable: selection starts sequencer at selection vector.
// - Select answer enable permits selection answer; cleared by disconnect, reset, connect.
// - Read-only field holds address of last instruction that raised instruction interrupt.
// - Program counter reads executing address while running, last address when idle.
// - Idle, no interrupt, bit 7 clear: write starts normal run at address.
// - Same conditions, bit 7 set: one instruction, then halt at next address.
// - Interrupt pending while idle: write ignored, stays idle, start rejected raised.
// - Write while running: address kept, run continues, start rejected raised.
// - Wide bit selects 16-bit data phase; software negotiates width first.
// - Six-bit synchronous offset; zero selects asynchronous handshake.
// - Three-bit field sets minimum negated width of REQ and ACK in clocks.
// - Three-bit field sets minimum asserted width of REQ and ACK in clocks.
`timescale 1ns/1ps
`default_nettype none
`include "sscr_map.vh"
module sscr_regs (
  input wire clk, // System clock
  input wire rst, // Async reset, active high
  input wire [6:0] reg_addr, // Register address
  input wire [7:0] reg_wdata, // Write data
  input wire reg_wr, // Write strobe, one cycle
  input wire reg_rd, // Read strobe, one cycle
  output reg [7:0] reg_rdata_reg, // Read data
  input wire target_mode, // High in target mode
  input wire dma_master, // SCSI section is DMA master
  input wire dir_send, // High when sending to SCSI bus
  input wire xfer_active, // Non register-file transfer running
  input wire block_boundary, // Transfer sits on a block boundary
  input wire fifo_empty, // Data FIFO empty
  input wire pipe_busy_to_idle, // Count pipeline busy to idle pulse
  input wire bsy_answer, // Device answered (re)selection with BSY
  input wire bus_connect, // Any connection to the bus
  input wire bus_reset_irq, // Bus reset interrupt pulse
  input wire unexpected_disconnect_irq, // Unexpected disconnect pulse
  input wire selected_pin, // Selected by another device (async)
  input wire reselected_pin, // Reselected by another device (async)
  input wire dma_req_pin, // DMA request (async)
  input wire [6:0] selection_vector, // Start address on selection
  input wire [6:0] reselection_vector, // Start address on reselection
  input wire [6:0] dma_reconnect_vector, // Start address on reconnect
  input wire interrupt_status_raw, // Any raw status bit set
  input wire instr_done, // Sequencer instruction completed
  input wire [6:0] instr_next_addr, // Next address of normal flow
  input wire instr_int, // Completed instruction set interrupt flag
  input wire instr_stop, // Completed instruction halts sequencer
  output reg seq_running_reg, // Sequencer running
  output reg [6:0] sequencer_pc_reg, // Current address
  output reg seq_start_reg, // Start pulse
  output reg start_rejected_irq_reg, // Start rejected pulse
  output reg select_answer_enable_reg, // Low-level selection enable
  output reg reselect_answer_enable_reg, // Low-level reselection enable
  output reg pause_dma_reg, // Stop DMA port side
  output reg pause_scsi_reg, // Stop SCSI side
  output reg xfer_done_reg, // Transfer part of instruction ended
  output reg wide_data_phase_reg, // 16-bit data phase
  output reg [5:0] sync_offset_reg, // Max synchronous offset
  output reg async_mode_reg, // Offset zero
  output reg [2:0] negated_width_reg, // REQ/ACK negated width
  output reg [2:0] asserted_width_reg // REQ/ACK asserted width
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  reg clear_all_on_high_clear_reg;
  reg block_boundary_pause_reg;
  reg dma_reconnect_enable_reg;
  reg reselect_vector_enable_reg;
  reg select_vector_enable_reg;
  reg [6:0] interrupting_instr_address_reg;
  reg step_mode_reg;
  reg extra_block_reg;
  reg seen_off_reg;
  wire sel_rise;
  wire rsel_rise;
  wire dma_rise;
  wire wr_resp;
  wire wr_pc;
  wire sel_start;
  wire rsel_start;
  wire dma_start;
  wire hw_start;
  wire sel_drop;
  wire rsel_drop;
  wire low_clear;
  wire pause_ok;
  wire pause_hit;
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  sscr_edge u_sel (
    .clk(clk),
    .rst(rst),
    .pin(selected_pin),
    .level(),
    .rise(sel_rise)
  );
  sscr_edge u_rsel (
    .clk(clk),
    .rst(rst),
    .pin(reselected_pin),
    .level(),
    .rise(rsel_rise)
  );
  sscr_edge u_dma (
    .clk(clk),
    .rst(rst),
    .pin(dma_req_pin),
    .level(),
    .rise(dma_rise)
  );
  // ----------------------------------------
  // Decode and event terms
  // ----------------------------------------
  assign wr_resp = reg_wr & (reg_addr == `SSCR_OFF_RESP);
  assign wr_pc = reg_wr & (reg_addr == `SSCR_OFF_PC);
  // Hardware starts, selection ahead of reselection ahead of reconnect
  assign sel_start = sel_rise & select_vector_enable_reg & ~seq_running_reg;
  assign rsel_start = rsel_rise & reselect_vector_enable_reg & ~seq_running_reg;
  assign dma_start = dma_rise & dma_reconnect_enable_reg & ~seq_running_reg;
  assign hw_start = sel_start | rsel_start | dma_start;
  // Vector enables dropping by software write
  assign sel_drop = wr_resp & select_vector_enable_reg & ~reg_wdata[`SSCR_B_SELV];
  assign rsel_drop = wr_resp & reselect_vector_enable_reg & ~reg_wdata[`SSCR_B_RSELV];
  // Common clear of both answer enables
  assign low_clear = bsy_answer | bus_connect | bus_reset_irq |
    unexpected_disconnect_irq;
  // Pause applies only in target mode as DMA master
  assign pause_ok = block_boundary_pause_reg & target_mode & dma_master &
    xfer_active;
  // No re-arm in the cycle the pause bit is being cleared
  assign pause_hit = pause_ok & block_boundary & ~extra_block_reg & ~seen_off_reg;
  // ----------------------------------------
  // Response register
  // ----------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      clear_all_on_high_clear_reg <= 1'b0;
      block_boundary_pause_reg <= 1'b0;
      dma_reconnect_enable_reg <= 1'b0;
      reselect_vector_enable_reg <= 1'b0;
      select_vector_enable_reg <= 1'b0;
      select_answer_enable_reg <= 1'b0;
      reselect_answer_enable_reg <= 1'b0;
    end else begin
      if (wr_resp) begin
        clear_all_on_high_clear_reg <= reg_wdata[`SSCR_B_ALLRESP];
        dma_reconnect_enable_reg <= reg_wdata[`SSCR_B_RECON];
        reselect_vector_enable_reg <= reg_wdata[`SSCR_B_RSELV];
        select_vector_enable_reg <= reg_wdata[`SSCR_B_SELV];
      end
      // Hardware clears of answer enables win over a write setting them
      if (low_clear) begin
        select_answer_enable_reg <= 1'b0;
        reselect_answer_enable_reg <= 1'b0;
      end else begin
        if (wr_resp) begin
          select_answer_enable_reg <= reg_wdata[`SSCR_B_SELA];
          reselect_answer_enable_reg <= reg_wdata[`SSCR_B_RSELA];
        end
        if (clear_all_on_high_clear_reg && sel_drop) begin
          select_answer_enable_reg <= 1'b0;
        end
        if (clear_all_on_high_clear_reg && rsel_drop) begin
          reselect_answer_enable_reg <= 1'b0;
        end
      end
      // Pause clears itself once the bus side has stopped
      if (seen_off_reg) begin
        block_boundary_pause_reg <= 1'b0;
      end else if (wr_resp) begin
        block_boundary_pause_reg <= reg_wdata[`SSCR_B_PAUSE];
      end
    end
  end
  // ----------------------------------------
  // Pause sequencing and transfer end
  // ----------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      extra_block_reg <= 1'b0;
      pause_dma_reg <= 1'b0;
      pause_scsi_reg <= 1'b0;
      seen_off_reg <= 1'b0;
      xfer_done_reg <= 1'b0;
    end else begin
      seen_off_reg <= 1'b0;
      xfer_done_reg <= 1'b0;
      // Receiving, set on a boundary: one more block before stopping
      if (wr_resp && reg_wdata[`SSCR_B_PAUSE] && !block_boundary_pause_reg &&
          !dir_send && block_boundary) begin
        extra_block_reg <= 1'b1;
      end else if (extra_block_reg && !block_boundary) begin
        extra_block_reg <= 1'b0;
      end
      if (pause_hit && dir_send) begin
        pause_dma_reg <= 1'b1;
      end
      if (pause_hit && !dir_send) begin
        pause_scsi_reg <= 1'b1;
      end
      // Stopped once FIFO drained (sending) or emptied (receiving)
      if ((pause_dma_reg || pause_scsi_reg) && fifo_empty && !seen_off_reg) begin
        pause_dma_reg <= 1'b0;
        pause_scsi_reg <= 1'b0;
        seen_off_reg <= 1'b1;
        xfer_done_reg <= 1'b1;
      end else if (pipe_busy_to_idle && !block_boundary_pause_reg) begin
        xfer_done_reg <= 1'b1;
      end
    end
  end
  // ----------------------------------------
  // Sequencer start, step and address
  // ----------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      seq_running_reg <= 1'b0;
      sequencer_pc_reg <= `SSCR_RST_PC;
      seq_start_reg <= 1'b0;
      start_rejected_irq_reg <= 1'b0;
      step_mode_reg <= 1'b0;
      interrupting_instr_address_reg <= `SSCR_RST_PC;
    end else begin
      seq_start_reg <= 1'b0;
      start_rejected_irq_reg <= 1'b0;
      if (seq_running_reg) begin
        if (wr_pc) begin
          start_rejected_irq_reg <= 1'b1;
        end
        if (instr_done) begin
          if (instr_int) begin
            interrupting_instr_address_reg <= sequencer_pc_reg;
          end
          // Idle keeps last executed address unless single step
          if (step_mode_reg) begin
            sequencer_pc_reg <= instr_next_addr;
            seq_running_reg <= 1'b0;
          end else if (instr_stop) begin
            seq_running_reg <= 1'b0;
          end else begin
            sequencer_pc_reg <= instr_next_addr;
          end
        end
      end else if (sel_start) begin
        sequencer_pc_reg <= selection_vector;
        seq_running_reg <= 1'b1;
        seq_start_reg <= 1'b1;
        step_mode_reg <= 1'b0;
        start_rejected_irq_reg <= wr_pc;
      end else if (rsel_start) begin
        sequencer_pc_reg <= reselection_vector;
        seq_running_reg <= 1'b1;
        seq_start_reg <= 1'b1;
        step_mode_reg <= 1'b0;
        start_rejected_irq_reg <= wr_pc;
      end else if (dma_start) begin
        sequencer_pc_reg <= dma_reconnect_vector;
        seq_running_reg <= 1'b1;
        seq_start_reg <= 1'b1;
        step_mode_reg <= 1'b0;
        start_rejected_irq_reg <= wr_pc;
      end else if (wr_pc) begin
        if (interrupt_status_raw) begin
          start_rejected_irq_reg <= 1'b1;
        end else begin
          sequencer_pc_reg <= reg_wdata[6:0];
          step_mode_reg <= reg_wdata[`SSCR_B_STEP];
          seq_running_reg <= 1'b1;
          seq_start_reg <= 1'b1;
        end
      end
    end
  end
  // ----------------------------------------
  // Transfer control and pulse width registers
  // ----------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wide_data_phase_reg <= 1'b0;
      sync_offset_reg <= 6'h00;
      async_mode_reg <= 1'b1;
      negated_width_reg <= `SSCR_RST_W3;
      asserted_width_reg <= `SSCR_RST_W3;
    end else begin
      if (reg_wr && reg_addr == `SSCR_OFF_XCTL) begin
        wide_data_phase_reg <= reg_wdata[`SSCR_B_WIDE];
        sync_offset_reg <= reg_wdata[5:0];
        async_mode_reg <= (reg_wdata[5:0] == 6'h00);
      end
      if (reg_wr && reg_addr == `SSCR_OFF_PWID) begin
        negated_width_reg <= reg_wdata[6:4];
        asserted_width_reg <= reg_wdata[2:0];
      end
    end
  end
  // ----------------------------------------
  // Read data, registered one cycle after the strobe
  // ----------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata_reg <= `SSCR_RST_BYTE;
    end else if (reg_rd) begin
      case (reg_addr)
        `SSCR_OFF_RESP: reg_rdata_reg <= {1'b0, clear_all_on_high_clear_reg,
          block_boundary_pause_reg, dma_reconnect_enable_reg,
          reselect_vector_enable_reg, reselect_answer_enable_reg,
          select_vector_enable_reg, select_answer_enable_reg};
        `SSCR_OFF_IADDR: reg_rdata_reg <= {1'b0, interrupting_instr_address_reg};
        `SSCR_OFF_PC: reg_rdata_reg <= {step_mode_reg, sequencer_pc_reg};
        `SSCR_OFF_XCTL: reg_rdata_reg <= {wide_data_phase_reg, 1'b0, sync_offset_reg};
        `SSCR_OFF_PWID: reg_rdata_reg <= {1'b0, negated_width_reg, 1'b0,
          asserted_width_reg};
        default: reg_rdata_reg <= `SSCR_RST_BYTE;
      endcase
    end
  end
endmodule // sscr_regs
`default_nettype wire

// ==== src/sscr_map.vh ====
`ifndef SSCR_MAP_VH
`define SSCR_MAP_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SSCR_OFF_RESP 7'h10
`define SSCR_OFF_IADDR 7'h12
`define SSCR_OFF_PC 7'h14
`define SSCR_OFF_XCTL 7'h16
`define SSCR_OFF_PWID 7'h18
// ----------------------------------------
// Response register fields, plus program counter step and transfer control wide bits
// ----------------------------------------
`define SSCR_B_ALLRESP 6
`define SSCR_B_PAUSE 5
`define SSCR_B_RECON 4
`define SSCR_B_RSELV 3
`define SSCR_B_SELV 1
`define SSCR_B_SELA 0
`define SSCR_B_RSELA 2
`define SSCR_B_STEP 7
`define SSCR_B_WIDE 7
// ----------------------------------------
// Reset values
// ----------------------------------------
`define SSCR_RST_BYTE 8'h00
`define SSCR_RST_PC 7'h00
`define SSCR_RST_W3 3'h0
// ----------------------------------------
// Timing counts
// ----------------------------------------
`define SSCR_DONE_LAT 2'h1
`endif

// ==== src/sscr_sync.v ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Three-stage synchroniser, change once stages 2 and 3 agree
// ----------------------------------------
module sscr_sync (
  input wire clk, // System clock
  input wire rst, // Async reset
  input wire d, // Pin input
  output reg q // Filtered level
);
  reg s1_reg;
  reg s2_reg;
  reg s3_reg;
  // Shift chain and agreement filter
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      q <= 1'b0;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        q <= s3_reg;
      end
    end
  end
endmodule // sscr_sync
`default_nettype wire

// ==== src/sscr_edge.v ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Synchronised pin with rising-edge pulse
// ----------------------------------------
module sscr_edge (
  input wire clk, // System clock
  input wire rst, // Async reset
  input wire pin, // Raw pin
  output wire level, // Clean level
  output wire rise // One-cycle rising pulse
);
  reg last_reg;
  sscr_sync u_sync (
    .clk(clk),
    .rst(rst),
    .d(pin),
    .q(level)
  );
  // Previous filtered level
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      last_reg <= 1'b0;
    end else begin
      last_reg <= level;
    end
  end
  assign rise = level & ~last_reg;
endmodule // sscr_edge
`default_nettype wire

// ==== verification/sscr_regs_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sscr_map.vh"
// ----------------------------------------
// Port checker for the register bank
// ----------------------------------------
module sscr_regs_monitor (
  input wire logic clk, // Clock
  input wire logic rst, // Reset
  input wire logic [6:0] reg_addr, // Address
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  input wire logic [7:0] reg_rdata_reg, // Read data
  input wire logic fifo_empty, // FIFO empty
  input wire logic bsy_answer, // BSY answer
  input wire logic bus_connect, // Connection
  input wire logic bus_reset_irq, // Bus reset
  input wire logic unexpected_disconnect_irq, // Disconnect
  input wire logic interrupt_status_raw, // Raw status
  input wire logic instr_done, // Instruction done
  input wire logic instr_int, // Interrupt flag
  input wire logic instr_stop, // Stop flag
  input wire logic seq_running_reg, // Running
  input wire logic [6:0] sequencer_pc_reg, // Address
  input wire logic start_rejected_irq_reg, // Rejected pulse
  input wire logic seq_start_reg, // Start pulse
  input wire logic select_answer_enable_reg, // Select answer
  input wire logic reselect_answer_enable_reg, // Reselect answer
  input wire logic pause_dma_reg, // DMA side paused
  input wire logic pause_scsi_reg, // SCSI side paused
  input wire logic xfer_done_reg // Transfer ended
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Decoded accesses
  logic pc_wr;
  logic unmapped;
  logic clr_any;
  assign pc_wr = reg_wr && reg_addr == `SSCR_OFF_PC;
  assign unmapped = !(reg_addr inside {`SSCR_OFF_RESP, `SSCR_OFF_IADDR, `SSCR_OFF_PC,
    `SSCR_OFF_XCTL, `SSCR_OFF_PWID});
  assign clr_any = bsy_answer || bus_connect || bus_reset_irq || unexpected_disconnect_irq;
  // Relations at the ports
  chk_pc_start: assert property (
    pc_wr && !seq_running_reg && !interrupt_status_raw && !reg_wdata[7]
    |=> seq_start_reg && seq_running_reg) else $error("idle write did not start");
  chk_pend_reject: assert property (
    pc_wr && !seq_running_reg && interrupt_status_raw |=> start_rejected_irq_reg)
    else $error("pending write not rejected");
  chk_run_reject: assert property (
    pc_wr && seq_running_reg && !instr_done
    |=> start_rejected_irq_reg && seq_running_reg && $stable(sequencer_pc_reg))
    else $error("running write not rejected");
  chk_answer_drop: assert property (
    clr_any |=> !select_answer_enable_reg && !reselect_answer_enable_reg)
    else $error("answer enable survived clear");
  chk_pause_release: assert property (
    (pause_dma_reg || pause_scsi_reg) && fifo_empty
    |=> xfer_done_reg && !pause_dma_reg && !pause_scsi_reg) else $error("pause not released");
  chk_stop_halt: assert property (
    seq_running_reg && instr_done && instr_stop |=> !seq_running_reg)
    else $error("stop did not halt");
  chk_int_addr: assert property (
    seq_running_reg && instr_done && instr_int ##2 reg_rd && reg_addr == `SSCR_OFF_IADDR
    |=> reg_rdata_reg[6:0] == $past(sequencer_pc_reg, 3)) else $error("wrong interrupt address");
  chk_unmapped_zero: assert property (
    reg_rd && unmapped |=> reg_rdata_reg == 8'h00) else $error("unmapped read not zero");
endmodule // sscr_regs_monitor
bind sscr_regs sscr_regs_monitor mon_u (.*);
`default_nettype wire

// ==== verification/sscr_initiator.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Other bus device selecting or reselecting
// ----------------------------------------
module sscr_initiator (
  input wire logic [1:0] cmd, // Bit 0 selects, bit 1 reselects
  output logic selected_pin, // Selection seen by the device
  output logic reselected_pin // Reselection seen by the device
);
  // Idle bus at start
  initial begin
    selected_pin = 1'b0;
    reselected_pin = 1'b0;
  end
  // Skewed against the system clock, phases unrelated
  always @(cmd) begin
    selected_pin <= #3.7 cmd[0];
    reselected_pin <= #6.1 cmd[1];
  end
endmodule // sscr_initiator
`default_nettype wire

// ==== verification/sscr_regs_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sscr_map.vh"
module sscr_regs_bench;
  logic clk, rst, reg_wr, reg_rd, target_mode, dma_master, dir_send, xfer_active;
  logic block_boundary, fifo_empty, pipe_busy_to_idle, dma_req_pin, interrupt_status_raw;
  logic instr_done, instr_int, instr_stop, seq_running_reg, seq_start_reg, async_mode_reg;
  logic start_rejected_irq_reg, select_answer_enable_reg, reselect_answer_enable_reg;
  logic pause_dma_reg, pause_scsi_reg, xfer_done_reg, wide_data_phase_reg;
  logic selected_pin, reselected_pin;
  logic [6:0] reg_addr, instr_next_addr, sequencer_pc_reg;
  logic [7:0] reg_wdata, reg_rdata_reg;
  logic [5:0] sync_offset_reg;
  logic [2:0] negated_width_reg, asserted_width_reg;
  logic [3:0] clr;
  logic [1:0] cmd;
  int err_total, checks_done;
  // ----------------------------------------
  // Block, far-side device and clock
  // ----------------------------------------
  sscr_regs dut_u (.*, .bsy_answer(clr[0]), .bus_connect(clr[1]), .bus_reset_irq(clr[2]),
    .unexpected_disconnect_irq(clr[3]), .selection_vector(7'h31), .reselection_vector(7'h42),
    .dma_reconnect_vector(7'h53));
  sscr_initiator peer_u (.cmd(cmd), .selected_pin(selected_pin),
    .reselected_pin(reselected_pin));
  always #5 clk = ~clk;
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task cmp(input logic [7:0] g, input logic [7:0] e, input string m);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("BAD %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  // Bus tasks start with an idle edge so a strobe never falls and rises in one step
  task wr(input logic [6:0] a, input logic [7:0] d);
    tick(1);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick(1);
    reg_wr = 1'b0;
  endtask
  task rd(input logic [6:0] a, input logic [7:0] e, input string m);
    tick(1);
    reg_addr = a;
    reg_rd = 1'b1;
    tick(1);
    reg_rd = 1'b0;
    cmp(reg_rdata_reg, e, m);
  endtask
  task fin(input logic [6:0] n, input logic i, input logic s);
    instr_next_addr = n;
    instr_int = i;
    instr_stop = s;
    instr_done = 1'b1;
    tick(1);
    {instr_done, instr_int, instr_stop} = 3'h0;
  endtask
  function automatic logic sig(input int w);
    case (w)
      0: sig = seq_start_reg;
      1: sig = pause_dma_reg;
      2: sig = pause_scsi_reg;
      default: sig = xfer_done_reg;
    endcase
  endfunction
  task wait_hi(input int w);
    int n;
    n = 0;
    while (sig(w) !== 1'b1 && n < 30) begin
      tick(1);
      n++;
    end
    cmp(sig(w), 1'b1, "awaited output");
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reset;
    logic [6:0] a [6];
    a = '{`SSCR_OFF_RESP, `SSCR_OFF_IADDR, `SSCR_OFF_PC, `SSCR_OFF_XCTL, `SSCR_OFF_PWID, 7'h1a};
    foreach (a[i]) rd(a[i], 8'h00, "reset or unmapped read");
    cmp(async_mode_reg, 1'b1, "reset async");
    $display("test reset done");
  endtask
  task t_fields;
    wr(`SSCR_OFF_XCTL, 8'hff);
    cmp({wide_data_phase_reg, async_mode_reg, sync_offset_reg}, 8'hbf, "wide");
    rd(`SSCR_OFF_XCTL, 8'hbf, "transfer control");
    wr(`SSCR_OFF_XCTL, 8'h01);
    cmp(async_mode_reg, 1'b0, "offset one");
    wr(`SSCR_OFF_XCTL, 8'h00);
    cmp({wide_data_phase_reg, async_mode_reg}, 2'b01, "narrow async");
    wr(`SSCR_OFF_PWID, 8'hff);
    rd(`SSCR_OFF_PWID, 8'h77, "pulse widths");
    wr(`SSCR_OFF_PWID, 8'h25);
    cmp({negated_width_reg, asserted_width_reg}, 6'h15, "width fields");
    $display("test fields done");
  endtask
  task t_seq;
    wr(`SSCR_OFF_PC, 8'h05);
    cmp({seq_start_reg, seq_running_reg, sequencer_pc_reg}, 9'h185, "start");
    wr(`SSCR_OFF_PC, 8'h22);
    cmp({start_rejected_irq_reg, sequencer_pc_reg}, 8'h85, "running write");
    fin(7'h06, 1'b1, 1'b0);
    rd(`SSCR_OFF_IADDR, 8'h05, "interrupt address");
    cmp(sequencer_pc_reg, 7'h06, "advance");
    fin(7'h09, 1'b0, 1'b1);
    rd(`SSCR_OFF_PC, 8'h06, "idle address");
    wr(`SSCR_OFF_PC, 8'h90);
    fin(7'h11, 1'b0, 1'b0);
    cmp({seq_running_reg, sequencer_pc_reg}, 8'h11, "single step");
    interrupt_status_raw = 1'b1;
    wr(`SSCR_OFF_PC, 8'h03);
    cmp({start_rejected_irq_reg, seq_running_reg, sequencer_pc_reg}, 9'h111, "pending");
    interrupt_status_raw = 1'b0;
    $display("test sequencer done");
  endtask
  task t_answer;
    for (int k = 0; k < 4; k++) begin
      wr(`SSCR_OFF_RESP, 8'h05);
      cmp({reselect_answer_enable_reg, select_answer_enable_reg}, 2'b11, "set");
      clr[k] = 1'b1;
      tick(1);
      clr = 4'h0;
      cmp({reselect_answer_enable_reg, select_answer_enable_reg}, 2'b00, "clear");
    end
    wr(`SSCR_OFF_RESP, 8'h0f);
    wr(`SSCR_OFF_RESP, 8'h05);
    cmp({reselect_answer_enable_reg, select_answer_enable_reg}, 2'b11, "kept");
    wr(`SSCR_OFF_RESP, 8'h4f);
    wr(`SSCR_OFF_RESP, 8'h45);
    rd(`SSCR_OFF_RESP, 8'h40, "all response");
    $display("test answer done");
  endtask
  task t_hw;
    logic [7:0] en [3];
    logic [6:0] vec [3];
    en = '{8'h02, 8'h08, 8'h10};
    vec = '{7'h31, 7'h42, 7'h53};
    for (int i = 0; i < 3; i++) begin
      wr(`SSCR_OFF_RESP, en[i]);
      if (i < 2) cmd[i] = 1'b1;
      else dma_req_pin = 1'b1;
      wait_hi(0);
      cmp(sequencer_pc_reg, vec[i], "vector start");
      fin(7'h00, 1'b0, 1'b1);
      cmd = 2'b00;
      dma_req_pin = 1'b0;
      tick(8);
    end
    wr(`SSCR_OFF_RESP, 8'h00);
    cmd = 2'b01;
    tick(10);
    cmp(seq_running_reg, 1'b0, "disabled select");
    cmd = 2'b00;
    tick(8);
    $display("test hardware start done");
  endtask
  task t_pause;
    {dma_master, xfer_active, dir_send, block_boundary} = 4'hf;
    wr(`SSCR_OFF_RESP, 8'h20);
    tick(3);
    cmp(pause_dma_reg, 1'b0, "initiator mode");
    target_mode = 1'b1;
    wait_hi(1);
    tick(2);
    cmp({pause_dma_reg, pause_scsi_reg}, 2'b10, "send hold");
    fifo_empty = 1'b1;
    wait_hi(3);
    rd(`SSCR_OFF_RESP, 8'h00, "pause cleared");
    {fifo_empty, dir_send} = 2'b00;
    wr(`SSCR_OFF_RESP, 8'h20);
    tick(4);
    cmp(pause_scsi_reg, 1'b0, "one more block");
    block_boundary = 1'b0;
    tick(3);
    block_boundary = 1'b1;
    wait_hi(2);
    cmp(pause_dma_reg, 1'b0, "receive side");
    fifo_empty = 1'b1;
    wait_hi(3);
    tick(1); // Pause bit clears one edge after the release
    pipe_busy_to_idle = 1'b1;
    tick(1);
    pipe_busy_to_idle = 1'b0;
    wait_hi(3);
    $display("test pause done");
  endtask
  // ----------------------------------------
  // Verdict, watchdog and main sequence
  // ----------------------------------------
  task final_report;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    err_total++;
    $display("BAD %0t watchdog expired", $time);
    final_report;
  end
  initial begin
    {clk, reg_wr, reg_rd, target_mode, dma_master, dir_send, xfer_active} = 7'h00;
    {block_boundary, fifo_empty, pipe_busy_to_idle, dma_req_pin} = 4'h0;
    {interrupt_status_raw, instr_done, instr_int, instr_stop} = 4'h0;
    {reg_addr, instr_next_addr, reg_wdata, clr, cmd} = 28'h000_0000;
    err_total = 0;
    checks_done = 0;
    rst = 1'b1;
    tick(12);
    rst = 1'b0;
    t_reset;
    t_fields;
    t_seq;
    t_answer;
    t_hw;
    t_pause;
    final_report;
  end
endmodule // sscr_regs_bench
`default_nettype wire
